/* File: verilog/clock_startup_reset_delay.sv */
// Start-up reset sequencer: time-out, oscillator count, sleep wake.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module clock_startup_reset_delay #(
  parameter logic [15:0] TOUT_LONG_CYCLES = startup_pkg::TOUT_LONG_CYCLES,
  parameter logic [15:0] START_16K_CYCLES = startup_pkg::START_16K_CYCLES,
  parameter logic [15:0] START_32K_CYCLES = startup_pkg::START_32K_CYCLES
) (
  // Clock, reset and freeze.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Other reset sources and wake event, same clock domain.
  input  wire logic        rst_sources_active,
  input  wire logic        wake_request,
  // Oscillator pins, asynchronous to sys_clk.
  input  wire logic        wdt_osc_in,
  input  wire logic        main_osc_in,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Reset and clock outputs.
  output logic             internal_reset,
  output logic             cpu_clock_hold,
  output logic             sys_clock_tick,
  // Decoded oscillator mode.
  output logic             lp_xtal_mode,
  output logic [1:0]       freq_range
);

  localparam int CW = startup_pkg::CNT_W;

  startup_pkg::fuse_s    fuse_ff;
  startup_pkg::startup_s cfg;
  startup_pkg::state_e   state_ff;
  startup_pkg::state_e   nxt_state;

  logic [CW-1:0] target_ff;
  logic [CW-1:0] nxt_target;
  logic [CW-1:0] wdt_count;
  logic [CW-1:0] osc_count;
  logic [31:0]   rdata_ff;
  logic [2:0]    div_cnt_ff;
  logic          wdt_edge;
  logic          osc_edge;
  logic          internal_reset_ff;
  logic          hold_ff;
  logic          tick_ff;
  logic          lp_ff;
  logic [1:0]    range_ff;

  // Start count in oscillator cycles for a decoded selection.
  function automatic logic [CW-1:0] start_cycles(
    input startup_pkg::start_e sel
  );
    logic [CW-1:0] n;
    n = startup_pkg::START_6_CYCLES;
    unique case (sel)
      startup_pkg::START_6:   n = startup_pkg::START_6_CYCLES;
      startup_pkg::START_258: n = startup_pkg::START_258_CYCLES;
      startup_pkg::START_1K:  n = startup_pkg::START_1K_CYCLES;
      startup_pkg::START_16K: n = START_16K_CYCLES;
      startup_pkg::START_32K: n = START_32K_CYCLES;
      default:                n = START_32K_CYCLES;
    endcase
    return n;
  endfunction : start_cycles

  // Time-out in watchdog cycles for a decoded selection.
  function automatic logic [CW-1:0] tout_cycles(
    input startup_pkg::tout_e sel
  );
    logic [CW-1:0] n;
    n = '0;
    unique case (sel)
      startup_pkg::TOUT_NONE:  n = '0;
      startup_pkg::TOUT_SHORT: n = startup_pkg::TOUT_SHORT_CYCLES;
      startup_pkg::TOUT_LONG:  n = TOUT_LONG_CYCLES;
      default:                 n = TOUT_LONG_CYCLES;
    endcase
    return n;
  endfunction : tout_cycles

  // Register decode.
  wire fuse_wr  = reg_wr && reg_addr == startup_pkg::ADDR_FUSE;
  wire sleep_wr = reg_wr && reg_addr == startup_pkg::ADDR_SLEEP;
  wire sleep_req = sleep_wr && reg_wdata[0];

  // Fuse bits read as 1 unprogrammed, 0 programmed.
  wire div8_programmed = !fuse_ff.divide_by_eight_fuse;

  // Phase completion compares against the target latched at entry.
  wire wdt_done = wdt_count >= target_ff;
  wire osc_done = osc_count >= target_ff;
  wire phase_change = clk_en && (nxt_state != state_ff);
  wire reset_phase = nxt_state == startup_pkg::ST_HOLD ||
                     nxt_state == startup_pkg::ST_TIMEOUT ||
                     nxt_state == startup_pkg::ST_OSC;

  // Read multiplexer; unmapped offsets read as zero.
  wire [31:0] status_word = {24'h0, div8_programmed, range_ff, lp_ff,
                             internal_reset_ff, state_ff};
  wire [31:0] rd_mux =
    (reg_addr == startup_pkg::ADDR_FUSE)   ? {25'h0, fuse_ff} :
    (reg_addr == startup_pkg::ADDR_STATUS) ? status_word :
    (reg_addr == startup_pkg::ADDR_COUNT)  ?
      {16'h0, (state_ff == startup_pkg::ST_TIMEOUT) ? wdt_count
                                                     : osc_count} :
    32'h0;

  // Fuse decode into time-out, start count and range.
  startup_fuse_decoder u_decode (
    .fuses (fuse_ff),
    .cfg   (cfg)
  );

  // Watchdog oscillator edges time the power-up time-out.
  osc_edge_counter #(
    .CNT_W      (CW)
  ) u_wdt_cnt (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .osc_in     (wdt_osc_in),
    .clr        (phase_change),
    .edge_pulse (wdt_edge),
    .count      (wdt_count)
  );

  // Ripple count of the selected oscillator output.
  osc_edge_counter #(
    .CNT_W      (CW)
  ) u_osc_cnt (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .osc_in     (main_osc_in),
    .clr        (phase_change),
    .edge_pulse (osc_edge),
    .count      (osc_count)
  );

  // Sequence: hold, time-out, oscillator count, run, sleep and wake.
  // The count is blind to supply level; only edges move it.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      startup_pkg::ST_HOLD:
        if (cfg.tout == startup_pkg::TOUT_NONE)
          nxt_state = startup_pkg::ST_OSC;
        else
          nxt_state = startup_pkg::ST_TIMEOUT;
      startup_pkg::ST_TIMEOUT:
        if (wdt_done)
          nxt_state = startup_pkg::ST_OSC;
      startup_pkg::ST_OSC:
        if (osc_done)
          nxt_state = startup_pkg::ST_RUN;
      startup_pkg::ST_RUN:
        if (sleep_req)
          nxt_state = startup_pkg::ST_SLEEP;
      startup_pkg::ST_SLEEP:
        if (wake_request)
          nxt_state = startup_pkg::ST_WAKE;
      startup_pkg::ST_WAKE:
        if (osc_done)
          nxt_state = startup_pkg::ST_RUN;
      default:
        nxt_state = startup_pkg::ST_HOLD;
    endcase
    // Any other reset source restarts the whole sequence.
    if (rst_sources_active)
      nxt_state = startup_pkg::ST_HOLD;
  end

  // Target for the phase being entered, latched so a fuse write
  // during a phase cannot move its end point.
  always_comb
  begin
    nxt_target = target_ff;
    if (nxt_state == startup_pkg::ST_TIMEOUT)
      nxt_target = tout_cycles(cfg.tout);
    else if (nxt_state == startup_pkg::ST_OSC)
      nxt_target = start_cycles(cfg.start) + cfg.extra;
    else if (nxt_state == startup_pkg::ST_WAKE)
      nxt_target = start_cycles(cfg.start);
  end

  // State and target registers.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_ff  <= startup_pkg::ST_HOLD;
      target_ff <= '0;
    end
    else if (phase_change)
    begin
      state_ff  <= nxt_state;
      target_ff <= nxt_target;
    end
  end

  // Fuse register, loaded with the shipping defaults.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      fuse_ff <= startup_pkg::FUSE_RESET;
    else if (clk_en && fuse_wr)
      fuse_ff <= startup_pkg::fuse_s'(reg_wdata[6:0]);
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_ff <= 32'h0;
    else if (clk_en)
      rdata_ff <= reg_rd ? rd_mux : 32'h0;
  end

  // Reset and clock hold outputs follow the next state.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      internal_reset_ff <= 1'b1;
      hold_ff           <= 1'b1;
      lp_ff             <= 1'b0;
      range_ff          <= 2'h0;
    end
    else if (clk_en)
    begin
      internal_reset_ff <= reset_phase;
      hold_ff           <= nxt_state != startup_pkg::ST_RUN;
      lp_ff             <= cfg.lp_xtal;
      range_ff          <= cfg.range;
    end
  end

  // System clock ticks from oscillator edges, every eighth edge when
  // the divide fuse is programmed. Ticks stop while the clock is held.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      div_cnt_ff <= 3'h0;
      tick_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (osc_edge)
        div_cnt_ff <= div_cnt_ff + 3'h1;
      tick_ff <= osc_edge && !hold_ff &&
                 (!div8_programmed ||
                  div_cnt_ff == startup_pkg::DIV8_LAST);
    end
  end

  assign reg_rdata      = rdata_ff;
  assign internal_reset = internal_reset_ff;
  assign cpu_clock_hold = hold_ff;
  assign sys_clock_tick = tick_ff;
  assign lp_xtal_mode   = lp_ff;
  assign freq_range     = range_ff;

  // Checks on the sequence; all share one clock and the reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence release_s;
    clk_en && !rst_sources_active;
  endsequence

  sequence tout_end_s;
    state_ff == startup_pkg::ST_TIMEOUT && wdt_done ##0 release_s;
  endsequence

  sequence osc_end_s;
    state_ff == startup_pkg::ST_OSC && osc_done ##0 release_s;
  endsequence

  hold_on_source_a: assert property (
    clk_en && rst_sources_active |=>
      state_ff == startup_pkg::ST_HOLD ##1 internal_reset)
    else $error("Reset source did not hold the sequence.");

  timeout_bound_a: assert property (
    state_ff == startup_pkg::ST_TIMEOUT |->
      target_ff == startup_pkg::TOUT_SHORT_CYCLES ||
      target_ff == TOUT_LONG_CYCLES)
    else $error("Time-out target is not 512 or the long count.");

  order_phases_a: assert property (
    tout_end_s |=> state_ff == startup_pkg::ST_OSC && osc_count == '0
      && internal_reset)
    else $error("Oscillator count did not follow the time-out.");

  release_reset_a: assert property (
    osc_end_s |=> state_ff == startup_pkg::ST_RUN && !internal_reset
      && !cpu_clock_hold)
    else $error("Reset not released after oscillator count.");

  reset_phase_a: assert property (
    state_ff == startup_pkg::ST_OSC && !osc_done && clk_en
      && !rst_sources_active |=> internal_reset)
    else $error("Reset dropped before oscillator count ended.");

  wake_skip_a: assert property (
    state_ff == startup_pkg::ST_SLEEP && wake_request ##0 release_s
      |=> state_ff == startup_pkg::ST_WAKE &&
          target_ff == start_cycles(cfg.start) && !internal_reset)
    else $error("Wake did not go straight to oscillator count.");

  zero_tout_a: assert property (
    state_ff == startup_pkg::ST_HOLD && cfg.tout ==
      startup_pkg::TOUT_NONE ##0 release_s |=>
      state_ff == startup_pkg::ST_OSC)
    else $error("Zero time-out did not skip the watchdog count.");

  range_decode_a: assert property (
    clk_en && fuse_ff.clock_source_select_fuses[3] |=>
      lp_xtal_mode && freq_range ==
      $past(fuse_ff.clock_source_select_fuses[2:1]))
    else $error("Low-power crystal range not decoded.");

  divide_tick_a: assert property (
    sys_clock_tick && div8_programmed && $stable(fuse_ff) |->
      $past(div_cnt_ff) == startup_pkg::DIV8_LAST)
    else $error("Divided clock ticked off the eighth edge.");

  fuse_default_a: assert property (
    $fell(sys_rst) |-> fuse_ff == startup_pkg::FUSE_RESET
      && state_ff == startup_pkg::ST_HOLD)
    else $error("Fuse word not at its default after reset.");

endmodule : clock_startup_reset_delay

/* File: verilog/startup_pkg.sv */
// Constants and types shared by the start-up reset sequencer.
// Notes on behaviour
// - Power-up time-out counts 0, 512 or 8192 cycles.
// - Time-out is a pure count, no voltage sensing.
// - Ripple count of oscillator holds internal reset.
// - Start count spans 6 up to 32K cycles.
// - From reset, time-out then oscillator count.
// - Wake from sleep uses oscillator count only.
// - Low-power crystal bits 3..1 select range.
// - Programmed divide fuse divides clock by eight.
// - Select bit 0 plus start fuses: eight choices.
// - Select bit 0 low start-up table.
// - Select bit 0 high start-up table.
// - Time-out timed from watchdog oscillator edges.
// - Fuse value 1 unprogrammed, 0 programmed.
// - Fuse defaults 0010, 10, divide programmed.
package startup_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_FUSE   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT  = 4'h8;
  localparam logic [3:0] ADDR_SLEEP  = 4'hc;

  // Cycle counts, in cycles of the oscillator being counted.
  localparam int          CNT_W              = 16;
  localparam logic [15:0] TOUT_SHORT_CYCLES  = 16'h0200;
  localparam logic [15:0] TOUT_LONG_CYCLES   = 16'h2000;
  localparam logic [15:0] START_6_CYCLES     = 16'h0006;
  localparam logic [15:0] START_258_CYCLES   = 16'h0102;
  localparam logic [15:0] START_1K_CYCLES    = 16'h0400;
  localparam logic [15:0] START_16K_CYCLES   = 16'h4000;
  localparam logic [15:0] START_32K_CYCLES   = 16'h8000;
  localparam logic [15:0] EXTRA_XTAL_CYCLES  = 16'h000e;
  localparam logic [15:0] EXTRA_LOWF_CYCLES  = 16'h0004;
  localparam logic [15:0] EXTRA_NONE_CYCLES  = 16'h0000;
  localparam logic [2:0]  DIV8_LAST          = 3'h7;

  // Fuse word after reset: divide programmed, start 10, select 0010.
  localparam logic [6:0]  FUSE_RESET         = 7'h22;

  typedef struct packed {
    logic       divide_by_eight_fuse;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } fuse_s;

  typedef enum logic [1:0] {
    TOUT_NONE  = 2'b00,
    TOUT_SHORT = 2'b01,
    TOUT_LONG  = 2'b10
  } tout_e;

  typedef enum logic [2:0] {
    START_6   = 3'b000,
    START_258 = 3'b001,
    START_1K  = 3'b010,
    START_16K = 3'b011,
    START_32K = 3'b100
  } start_e;

  typedef struct packed {
    tout_e       tout;
    start_e      start;
    logic [15:0] extra;
    logic        lp_xtal;
    logic [1:0]  range;
  } startup_s;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_OSC     = 3'b010,
    ST_RUN     = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_WAKE    = 3'b101
  } state_e;

endpackage : startup_pkg

/* File: verilog/osc_edge_counter.sv */
// Synchroniser and saturating edge counter for one oscillator input.
`timescale 1ns/10ps
module osc_edge_counter #(
  parameter int CNT_W = 16
) (
  // Clock, reset and freeze.
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Oscillator pin and phase clear.
  input  wire logic             osc_in,
  input  wire logic             clr,
  // Edge pulse and running count.
  output logic                  edge_pulse,
  output logic [CNT_W-1:0]      count
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Two flops before use; only sync_ff and last_ff feed the edge detect.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_ff <= osc_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign edge_pulse = clk_en & sync_ff & ~last_ff;

  // Clear wins over an edge so a new phase always starts from zero.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      count <= '0;
    else if (clk_en)
    begin
      if (clr)
        count <= '0;
      else if (edge_pulse && !(&count))
        count <= count + 1'b1;
    end
  end

endmodule : osc_edge_counter

/* File: verilog/startup_fuse_decoder.sv */
// Decoder from the fuse word to time-out, start count and range.
`timescale 1ns/10ps
module startup_fuse_decoder (
  // Fuse word in.
  input  startup_pkg::fuse_s    fuses,
  // Decoded start-up settings out.
  output startup_pkg::startup_s cfg
);

  wire [3:0] sel;
  wire [2:0] idx;
  wire       lp;
  wire       full_swing;
  wire       low_freq;
  startup_pkg::tout_e  xtal_tout;
  startup_pkg::tout_e  sut_tout;
  startup_pkg::start_e xtal_start;

  // Source classes from select bits 3..1.
  assign sel        = fuses.clock_source_select_fuses;
  assign lp         = sel[3];
  assign full_swing = sel[3:1] == 3'h3;
  assign low_freq   = sel[3:1] == 3'h2;
  assign idx        = {sel[0], fuses.startup_time_fuses};

  // Crystal table, time-out column per combination.
  assign xtal_tout  = (idx == 3'h2 || idx == 3'h5) ? startup_pkg::TOUT_NONE :
                      (idx == 3'h1 || idx == 3'h4 || idx == 3'h7) ?
                      startup_pkg::TOUT_LONG : startup_pkg::TOUT_SHORT;
  // Crystal table, wake count column per combination.
  assign xtal_start = (idx <= 3'h1) ? startup_pkg::START_258 :
                      (idx <= 3'h4) ? startup_pkg::START_1K :
                      startup_pkg::START_16K;
  // Other sources: 00 none, 01 short, otherwise long.
  assign sut_tout   = (fuses.startup_time_fuses == 2'h0) ?
                      startup_pkg::TOUT_NONE :
                      (fuses.startup_time_fuses == 2'h1) ?
                      startup_pkg::TOUT_SHORT : startup_pkg::TOUT_LONG;

  // Start count spans external clock up to low-frequency crystal.
  assign cfg.tout    = (lp || full_swing) ? xtal_tout : sut_tout;
  assign cfg.start   = (lp || full_swing) ? xtal_start :
                       low_freq ? (sel[0] ? startup_pkg::START_32K :
                                            startup_pkg::START_1K) :
                       startup_pkg::START_6;
  assign cfg.extra   = (lp || full_swing) ? startup_pkg::EXTRA_XTAL_CYCLES :
                       low_freq ? startup_pkg::EXTRA_LOWF_CYCLES :
                       startup_pkg::EXTRA_NONE_CYCLES;
  assign cfg.lp_xtal = lp;
  assign cfg.range   = lp ? sel[2:1] : 2'h0;

endmodule : startup_fuse_decoder

/* File: test/osc_source_model.sv */
// Behavioural ceramic resonator and watchdog oscillator for the bench.
`timescale 1ns/10ps
module osc_source_model #(
  parameter real WDT_HALF_NS  = 41.0,
  parameter real MAIN_HALF_NS = 31.0
) (
  // Start control for the main resonator.
  input  wire logic main_en,
  // Oscillator pins.
  output logic      wdt_osc_in,
  output logic      main_osc_in
);
  // The watchdog oscillator runs free from power-on.
  initial
  begin
    wdt_osc_in = 1'b0;
    forever #(WDT_HALF_NS) wdt_osc_in = ~wdt_osc_in;
  end

  // A ceramic resonator, never a crystal, so the lowest band and the
  // short start options are legal; a stopped resonator sits low.
  initial
  begin
    main_osc_in = 1'b0;
    forever
    begin
      #(MAIN_HALF_NS);
      main_osc_in = main_en ? ~main_osc_in : 1'b0;
    end
  end
endmodule : osc_source_model

/* File: test/tb.sv */
// Self-checking bench for the start-up reset sequencer.
`timescale 1ns/10ps
module tb;
  localparam real WDT_P  = 8.2;
  localparam real MAIN_P = 6.2;
  localparam int  LONG_T = 16;
  localparam int  K16    = 20;
  localparam int  K32    = 24;

  typedef struct {
    logic [6:0] fuse;
    int         tout;
    int         start;
    int         extra;
  } case_s;

  logic        sys_clk            = 1'b0;
  logic        sys_rst            = 1'b1;
  logic        clk_en             = 1'b1;
  logic        rst_sources_active = 1'b1;
  logic        wake_request       = 1'b0;
  logic        main_en            = 1'b1;
  logic [3:0]  reg_addr           = 4'h0;
  logic [31:0] reg_wdata          = 32'h0;
  logic        reg_wr             = 1'b0;
  logic        reg_rd             = 1'b0;
  logic        wdt_osc_in;
  logic        main_osc_in;
  logic [31:0] reg_rdata;
  logic        internal_reset;
  logic        cpu_clock_hold;
  logic        sys_clock_tick;
  logic        lp_xtal_mode;
  logic [1:0]  freq_range;
  int          error_cnt          = 0;
  int          compares           = 0;
  case_s       cases [12];

  // Free-running system clock.
  always #5 sys_clk = ~sys_clk;

  osc_source_model osc_u (
    .main_en     (main_en),
    .wdt_osc_in  (wdt_osc_in),
    .main_osc_in (main_osc_in)
  );

  // Long counts shortened so all twelve fuse cases fit one run.
  clock_startup_reset_delay #(
    .TOUT_LONG_CYCLES (16'(LONG_T)),
    .START_16K_CYCLES (16'(K16)),
    .START_32K_CYCLES (16'(K32))
  ) dut_u (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .clk_en             (clk_en),
    .rst_sources_active (rst_sources_active),
    .wake_request       (wake_request),
    .wdt_osc_in         (wdt_osc_in),
    .main_osc_in        (main_osc_in),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .internal_reset     (internal_reset),
    .cpu_clock_hold     (cpu_clock_hold),
    .sys_clock_tick     (sys_clock_tick),
    .lp_xtal_mode       (lp_xtal_mode),
    .freq_range         (freq_range)
  );

  task automatic conclude();
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Cycle counts carry one oscillator period of phase slack per phase.
  task automatic span(input int n, input real nom, input string msg);
    logic ok;
    ok = (n >= nom - WDT_P - MAIN_P - 3.0) && (n <= nom + 12.0);
    check({31'h0, ok}, 32'h1, msg);
  endtask : span

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : reg_read

  task automatic wait_release(input logic on_hold, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 20000)
      begin
        error_cnt++;
        $display("BAD %0t release never came", $time);
        conclude();
      end
    end while ((on_hold ? cpu_clock_hold : internal_reset) !== 1'b0);
  endtask : wait_release

  task automatic reset_values();
    logic [31:0] d;
    reg_read(startup_pkg::ADDR_FUSE, d);
    check(d, 32'h22, "fuse reset");
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({24'h0, d[7:0]}, 32'h88, "status reset");
    check({31'h0, cpu_clock_hold}, 32'h1, "hold at reset");
  endtask : reset_values

  // Resonator never starts: reset must stay up until sources reassert.
  task automatic abort_case();
    logic [31:0] d;
    @(posedge sys_clk);
    main_en            <= 1'b0;
    reg_write(startup_pkg::ADDR_FUSE, 32'h22);
    @(posedge sys_clk);
    rst_sources_active <= 1'b0;
    repeat (400) @(posedge sys_clk);
    reg_write(startup_pkg::ADDR_SLEEP, 32'h1);
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({29'h0, d[2:0]}, 32'h2, "stuck in osc count");
    check({31'h0, internal_reset}, 32'h1, "reset held");
    // A stopped resonator gives no edges, so the ripple count stays at zero.
    reg_read(startup_pkg::ADDR_COUNT, d);
    check(d, 32'h0, "no edges counted");
    @(posedge sys_clk);
    rst_sources_active <= 1'b1;
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({29'h0, d[2:0]}, 32'h0, "forced hold");
    reg_read(4'h2, d);
    check(d, 32'h0, "unmapped read");
    @(posedge sys_clk);
    main_en            <= 1'b1;
  endtask : abort_case

  // Zero time-out cases assume a brown-out detector upstream.
  task automatic run_case(input case_s c);
    logic [31:0] d;
    int          n;
    int          t;
    int          et;
    t = 0;
    @(posedge sys_clk);
    rst_sources_active <= 1'b1;
    reg_write(startup_pkg::ADDR_FUSE, {25'h0, c.fuse});
    repeat (2) @(posedge sys_clk);
    #1;
    check({31'h0, lp_xtal_mode}, {31'h0, c.fuse[3]}, "lp mode");
    check({30'h0, freq_range}, {30'h0, c.fuse[3] ? c.fuse[2:1] : 2'b00},
          "range");
    @(posedge sys_clk);
    rst_sources_active <= 1'b0;
    wait_release(1'b0, n);
    span(n, c.tout * WDT_P + (c.start + c.extra) * MAIN_P,
         "reset delay");
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({28'h0, d[3:0]}, 32'h3, "run state");
    repeat (248)
    begin
      @(posedge sys_clk);
      #1;
      if (sys_clock_tick === 1'b1)
        t++;
    end
    et = c.fuse[6] ? 40 : 5;
    check({31'h0, (t >= et - 1) && (t <= et + 1)}, 32'h1,
          "tick rate");
    reg_write(startup_pkg::ADDR_SLEEP, 32'h1);
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({29'h0, d[2:0]}, 32'h4, "sleep state");
    // A wake strobe seen only while the block is frozen must be lost.
    @(posedge sys_clk);
    clk_en       <= 1'b0;
    wake_request <= 1'b1;
    @(posedge sys_clk);
    clk_en       <= 1'b1;
    wake_request <= 1'b0;
    reg_read(startup_pkg::ADDR_STATUS, d);
    check({29'h0, d[2:0]}, 32'h4, "frozen wake ignored");
    @(posedge sys_clk);
    wake_request <= 1'b1;
    @(posedge sys_clk);
    wake_request <= 1'b0;
    // Look while the wake count still runs, not after it ends.
    @(posedge sys_clk);
    #1;
    check({31'h0, internal_reset}, 32'h0, "reset in wake");
    check({31'h0, cpu_clock_hold}, 32'h1, "hold in wake");
    wait_release(1'b1, n);
    span(n, c.start * MAIN_P, "wake delay");
  endtask : run_case

  // Main sequence: reset, abort, then all eight crystal start-up settings and four other fuse words.
  initial
  begin
    cases[0]  = '{7'h22, LONG_T, 6, 0};
    cases[1]  = '{7'h08, 512, 258, 14};
    cases[2]  = '{7'h5a, LONG_T, 258, 14};
    cases[3]  = '{7'h2c, 0, 1024, 14};
    cases[4]  = '{7'h7e, 512, 1024, 14};
    cases[5]  = '{7'h49, LONG_T, 1024, 14};
    cases[6]  = '{7'h1b, 0, K16, 14};
    cases[7]  = '{7'h6d, 512, K16, 14};
    cases[8]  = '{7'h3f, LONG_T, K16, 14};
    cases[9]  = '{7'h65, LONG_T, K32, 4};
    cases[10] = '{7'h40, 0, 6, 0};
    cases[11] = '{7'h16, LONG_T, 258, 14};
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reset_values();
    abort_case();
    foreach (cases[i])
      run_case(cases[i]);
    conclude();
  end
endmodule : tb
